// >>> rtl/ssfb_pkg.sv
package ssfb_pkg;

    // ------------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    // Every half period is a multiple of 50 ms, so one shared tick
    // feeds all eight waveforms.
    localparam int TICK_PERIOD_MS = 50;
    localparam int TICK_CYCLES = TICK_PERIOD_MS * 1000000 / CLK_PERIOD_NS;
    localparam int TIMING_BITS = 8;
    localparam int HALF_PERIOD_MS [TIMING_BITS] =
        '{50, 100, 200, 400, 500, 1000, 2000, 4000};

    // ------------------------------------------------------------------
    // Register word indices (byte address is four times the index)
    // ------------------------------------------------------------------
    localparam logic [3:0] REG_TIMING = 4'h0;
    localparam logic [3:0] REG_PROG_ERR = 4'h1;
    localparam logic [3:0] REG_CAL_FIRST = 4'h2;
    localparam logic [3:0] REG_CAL_LAST = 4'h8;
    localparam logic [3:0] REG_CHECK = 4'h9;
    localparam logic [3:0] REG_IOMAP = 4'ha;
    localparam int CAL_REGS = 7;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int TB_CONST0 = 14;
    localparam int TB_CONST1 = 15;
    localparam int TB_CARRY = 16;
    localparam int TB_ERF = 17;
    localparam int PE_ILLEGAL = 0;
    localparam int PE_BOUNDARY = 4;
    localparam int PE_DEST = 5;
    localparam int PE_PROG_PAR = 6;
    localparam int PE_DATA_PAR = 7;
    localparam int PE_DIV = 8;
    localparam int PE_BCD = 9;
    localparam int PE_TABLE = 10;
    localparam int PE_ENCODE = 11;
    localparam int PE_LABEL = 12;
    localparam int PE_NEST = 13;
    localparam logic [15:0] PE_FATAL_MASK = 16'h00c1;
    localparam logic [15:0] PE_WARN_MASK = 16'h3f30;
    localparam int CK_TRIGGER = 0;
    localparam int CK_SUMMARY = 1;
    localparam int CK_RESULT_LSB = 2;
    localparam int CK_SELECT = 15;
    localparam int IO_TRIGGER = 0;

    // ------------------------------------------------------------------
    // Reset and fill values
    // ------------------------------------------------------------------
    localparam logic [15:0] PERR_RESET = 16'h0000;
    localparam logic [15:0] CAL_RESET = 16'h0000;
    localparam logic [15:0] CAL_FAULT_VALUE = 16'h00ff;
    // Order: year, month, day, hour, minute, second, weekday
    localparam logic [7:0] CAL_LO [CAL_REGS] =
        '{8'h00, 8'h01, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00};
    localparam logic [7:0] CAL_HI [CAL_REGS] =
        '{8'h99, 8'h12, 8'h31, 8'h23, 8'h59, 8'h59, 8'h06};

endpackage

// >>> rtl/ssfb_timing_gen.sv
`timescale 1ns/1ns
`default_nettype none
module ssfb_timing_gen
    import ssfb_pkg::*;
#(
    parameter int TICK_CYCLES_P = TICK_CYCLES
) (
    input wire logic i_mclk,
    input wire logic i_reset_n,
    input wire logic i_ce,
    input wire logic i_restart,
    output logic [TIMING_BITS-1:0] o_bits
);
    // ------------------------------------------------------------------
    // Shared 50 ms tick
    // ------------------------------------------------------------------
    logic [31:0] pre_reg;
    logic tick;
    assign tick = (pre_reg == 32'(TICK_CYCLES_P - 1));

    always_ff @(posedge i_mclk) begin
        if (!i_reset_n || (i_ce && i_restart)) begin
            pre_reg <= 32'h0;
        end else if (i_ce) begin
            pre_reg <= tick ? 32'h0 : pre_reg + 32'h1;
        end
    end

    // ------------------------------------------------------------------
    // Square waves, low half first
    // ------------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < TIMING_BITS; g++) begin : g_wave
            localparam logic [6:0] HALF =
                7'(HALF_PERIOD_MS[g] / TICK_PERIOD_MS);
            logic [6:0] cnt_reg;
            logic bit_reg;
            always_ff @(posedge i_mclk) begin
                if (!i_reset_n || (i_ce && i_restart)) begin
                    cnt_reg <= 7'h0;
                    bit_reg <= 1'b0;
                end else if (i_ce && tick) begin
                    if (cnt_reg == HALF - 7'h1) begin
                        cnt_reg <= 7'h0;
                        bit_reg <= ~bit_reg;
                    end else begin
                        cnt_reg <= cnt_reg + 7'h1;
                    end
                end
            end
            assign o_bits[g] = bit_reg;
        end
    endgenerate

endmodule // ssfb_timing_gen
`default_nettype wire

// >>> rtl/ssfb_status_bank.sv
// Notes on behaviour
// - Eight square waves, low then high, periods 0.1 s up to 8.0 s.
// - Carry flag is writable and read/updated by carry arithmetic.
// - Instruction error flag sets on any execution error; writable.
// - Other bits of the timing word ignore writes.
// - Illegal opcode sets a fatal flag.
// - Indirect address and indirect destination errors set warnings.
// - Program and data memory parity errors set separate fatal flags.
// - Divide, BCD, table and encode errors set their own warnings.
// - Unregistered jump or call label sets a warning.
// - Nesting overflow of call, loop or master control sets a warning.
// - RUN entry clears all error and warning flags.
// - Software may write warning flags; fatal flags ignore writes.
// - Calendar values are two BCD digits in the low byte.
// - Calendar ranges: year 00-99, month 01-12, day 01-31, etc.
// - Weekday codes Sunday 00 through Saturday 06.
// - Bus writes to calendar registers have no effect.
// - Unreadable calendar loads every calendar register with 00ff.
// - Check runs when trigger set, at the selected scan point.
// - Pattern and four register mismatch flags; summary is their OR.
// - I/O error mapping runs while its trigger bit is set.
// - Timing select 0 checks before the program, 1 after.
//
// The Avalon-MM slave port and the address map were decided locally.
`timescale 1ns/1ns
`default_nettype none
module ssfb_status_bank
    import ssfb_pkg::*;
#(
    parameter int TICK_CYCLES_P = TICK_CYCLES
) (
    input wire logic i_mclk,
    input wire logic i_reset_n,
    input wire logic i_ce,
    input wire logic [3:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    input wire logic i_run_mode,
    input wire logic i_carry_we,
    input wire logic i_carry_in,
    input wire logic i_err_illegal,
    input wire logic i_err_boundary,
    input wire logic i_err_dest,
    input wire logic i_err_prog_parity,
    input wire logic i_err_data_parity,
    input wire logic i_err_divide,
    input wire logic i_err_bcd,
    input wire logic i_err_table,
    input wire logic i_err_encode,
    input wire logic i_err_label,
    input wire logic i_err_nesting,
    input wire logic i_cal_update,
    input wire logic i_cal_fault,
    input wire logic [7:0] i_cal_year,
    input wire logic [7:0] i_cal_month,
    input wire logic [7:0] i_cal_day,
    input wire logic [7:0] i_cal_hour,
    input wire logic [7:0] i_cal_minute,
    input wire logic [7:0] i_cal_second,
    input wire logic [7:0] i_cal_weekday,
    input wire logic i_scan_pre,
    input wire logic i_scan_post,
    input wire logic i_check_done,
    input wire logic i_pattern_mismatch,
    input wire logic [3:0] i_reg_mismatch,
    output logic [TIMING_BITS-1:0] o_timing_bits,
    output logic o_carry_flag,
    output logic o_instruction_error_flag,
    output logic o_check_run,
    output logic o_io_error_map_run
);
    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic bcd_ok(input logic [7:0] v,
                                    input logic [7:0] lo,
                                    input logic [7:0] hi);
        // BCD compares correctly as plain binary once digits are legal
        bcd_ok = (v[7:4] <= 4'h9) && (v[3:0] <= 4'h9) && (v >= lo)
                 && (v <= hi);
    endfunction

    function automatic logic [31:0] lane_mask(input logic [3:0] be);
        lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    endfunction

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    logic wait_reg;
    logic [31:0] rdata_reg;
    logic run_prev_reg;
    logic carry_reg;
    logic erf_reg;
    logic [15:0] perr_reg;
    logic [15:0] cal_reg [CAL_REGS];
    logic check_trig_reg;
    logic check_sel_reg;
    logic [4:0] check_res_reg;
    logic check_run_reg;
    logic io_trig_reg;
    logic [TIMING_BITS-1:0] timing_bits;

    // ------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------
    // One wait cycle on every access: answer at the second edge.
    wire req = i_avs_read || i_avs_write;
    wire wr_go = i_avs_write && !wait_reg;
    wire [31:0] wmask = lane_mask(i_avs_byteenable);
    wire hit_timing = (i_avs_address == REG_TIMING);
    wire hit_perr = (i_avs_address == REG_PROG_ERR);
    wire hit_check = (i_avs_address == REG_CHECK);
    wire hit_iomap = (i_avs_address == REG_IOMAP);
    wire hit_cal = (i_avs_address >= REG_CAL_FIRST)
                   && (i_avs_address <= REG_CAL_LAST);
    wire [2:0] cal_idx = 3'(i_avs_address - REG_CAL_FIRST);
    wire run_start = i_run_mode && !run_prev_reg;

    // ------------------------------------------------------------------
    // Error events
    // ------------------------------------------------------------------
    logic [15:0] ev_vec;
    always_comb begin
        ev_vec = 16'h0;
        ev_vec[PE_ILLEGAL] = i_err_illegal;
        ev_vec[PE_BOUNDARY] = i_err_boundary;
        ev_vec[PE_DEST] = i_err_dest;
        ev_vec[PE_PROG_PAR] = i_err_prog_parity;
        ev_vec[PE_DATA_PAR] = i_err_data_parity;
        ev_vec[PE_DIV] = i_err_divide;
        ev_vec[PE_BCD] = i_err_bcd;
        ev_vec[PE_TABLE] = i_err_table;
        ev_vec[PE_ENCODE] = i_err_encode;
        ev_vec[PE_LABEL] = i_err_label;
        ev_vec[PE_NEST] = i_err_nesting;
    end
    wire any_ev = |ev_vec;
    wire [15:0] warn_wmask = PE_WARN_MASK & wmask[15:0];
    wire perr_wr = wr_go && hit_perr;
    // Fatal bits never take bus data; a new event beats a bus clear, RUN entry beats both.
    wire [15:0] perr_written = perr_wr
        ? ((perr_reg & ~warn_wmask) | (i_avs_writedata[15:0] & warn_wmask))
        : perr_reg;
    wire [15:0] perr_next = run_start ? PERR_RESET
                          : (perr_written | ev_vec);

    wire tw_wr = wr_go && hit_timing;
    // Only carry and error flag are writable in the timing word.
    wire carry_bus = tw_wr && wmask[TB_CARRY];
    wire erf_bus = tw_wr && wmask[TB_ERF];
    wire carry_next = i_carry_we ? i_carry_in
                    : carry_bus ? i_avs_writedata[TB_CARRY]
                    : carry_reg;
    wire erf_next = run_start ? 1'b0
                  : any_ev ? 1'b1
                  : erf_bus ? i_avs_writedata[TB_ERF]
                  : erf_reg;

    // ------------------------------------------------------------------
    // Calendar capture
    // ------------------------------------------------------------------
    logic [7:0] cal_in [CAL_REGS];
    assign cal_in[0] = i_cal_year;
    assign cal_in[1] = i_cal_month;
    assign cal_in[2] = i_cal_day;
    assign cal_in[3] = i_cal_hour;
    assign cal_in[4] = i_cal_minute;
    assign cal_in[5] = i_cal_second;
    assign cal_in[6] = i_cal_weekday;
    logic [CAL_REGS-1:0] cal_valid;
    genvar g;
    generate
        for (g = 0; g < CAL_REGS; g++) begin : g_calchk
            assign cal_valid[g] = bcd_ok(cal_in[g], CAL_LO[g],
                                         CAL_HI[g]);
        end
    endgenerate
    // Out-of-range data is treated as an unreadable chip.
    wire cal_bad = i_cal_fault || (i_cal_update && !(&cal_valid));

    // ------------------------------------------------------------------
    // Check and mapping triggers
    // ------------------------------------------------------------------
    wire ck_wr = wr_go && hit_check;
    wire io_wr = wr_go && hit_iomap;
    wire check_fire = check_trig_reg && ((i_scan_pre && !check_sel_reg)
                      || (i_scan_post && check_sel_reg));

    // ------------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------------
    logic [31:0] rd_word;
    always_comb begin
        rd_word = 32'h0;
        if (hit_timing) begin
            rd_word[TIMING_BITS-1:0] = timing_bits;
            rd_word[TB_CONST0] = 1'b0;
            rd_word[TB_CONST1] = 1'b1;
            rd_word[TB_CARRY] = carry_reg;
            rd_word[TB_ERF] = erf_reg;
        end else if (hit_perr) begin
            rd_word[15:0] = perr_reg;
        end else if (hit_cal) begin
            rd_word[15:0] = cal_reg[cal_idx];
        end else if (hit_check) begin
            rd_word[CK_TRIGGER] = check_trig_reg;
            rd_word[CK_SUMMARY] = |check_res_reg;
            rd_word[CK_RESULT_LSB +: 5] = check_res_reg;
            rd_word[CK_SELECT] = check_sel_reg;
        end else if (hit_iomap) begin
            rd_word[IO_TRIGGER] = io_trig_reg;
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge i_mclk) begin
        if (!i_reset_n) begin
            wait_reg <= 1'b1;
            rdata_reg <= 32'h0;
            run_prev_reg <= 1'b0;
        end else if (i_ce) begin
            wait_reg <= !(req && wait_reg);
            rdata_reg <= (i_avs_read && wait_reg) ? rd_word : rdata_reg;
            run_prev_reg <= i_run_mode;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_reset_n) begin
            carry_reg <= 1'b0;
            erf_reg <= 1'b0;
            perr_reg <= PERR_RESET;
        end else if (i_ce) begin
            carry_reg <= carry_next;
            erf_reg <= erf_next;
            perr_reg <= perr_next;
        end
    end

    // Bus writes never reach the calendar store.
    always_ff @(posedge i_mclk) begin
        if (!i_reset_n) begin
            for (int i = 0; i < CAL_REGS; i++) begin
                cal_reg[i] <= CAL_RESET;
            end
        end else if (i_ce && cal_bad) begin
            for (int i = 0; i < CAL_REGS; i++) begin
                cal_reg[i] <= CAL_FAULT_VALUE;
            end
        end else if (i_ce && i_cal_update) begin
            for (int i = 0; i < CAL_REGS; i++) begin
                cal_reg[i] <= {8'h00, cal_in[i]};
            end
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_reset_n) begin
            check_trig_reg <= 1'b0;
            check_sel_reg <= 1'b0;
            check_res_reg <= 5'h0;
            check_run_reg <= 1'b0;
            io_trig_reg <= 1'b0;
        end else if (i_ce) begin
            if (ck_wr && wmask[CK_TRIGGER]) begin
                check_trig_reg <= i_avs_writedata[CK_TRIGGER];
            end
            if (ck_wr && wmask[CK_SELECT]) begin
                check_sel_reg <= i_avs_writedata[CK_SELECT];
            end
            if (i_check_done) begin
                check_res_reg <= {i_reg_mismatch,
                                  i_pattern_mismatch};
            end
            check_run_reg <= check_fire;
            if (io_wr && wmask[IO_TRIGGER]) begin
                io_trig_reg <= i_avs_writedata[IO_TRIGGER];
            end
        end
    end

    // ------------------------------------------------------------------
    // Timing waves
    // ------------------------------------------------------------------
    ssfb_timing_gen #(
        .TICK_CYCLES_P(TICK_CYCLES_P)
    ) u_timing (
        .i_mclk(i_mclk),
        .i_reset_n(i_reset_n),
        .i_ce(i_ce),
        .i_restart(run_start),
        .o_bits(timing_bits)
    );

    assign o_timing_bits = timing_bits;
    assign o_avs_readdata = rdata_reg;
    assign o_avs_waitrequest = wait_reg;
    assign o_carry_flag = carry_reg;
    assign o_instruction_error_flag = erf_reg;
    assign o_check_run = check_run_reg;
    assign o_io_error_map_run = io_trig_reg;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_reset_n);

    a_const_bits_read: assert property (
        (i_ce && i_avs_read && wait_reg && hit_timing) |=>
        (o_avs_readdata[TB_CONST1:TB_CONST0] == 2'b10))
        else $error("constant bits read wrong");

    a_run_clears_flags: assert property (
        (i_ce && run_start) |=> (perr_reg == 16'h0) && !erf_reg)
        else $error("flags not cleared at run start");

    a_fatal_holds_write: assert property (
        (i_ce && !run_start && perr_wr && perr_reg[PE_PROG_PAR]) |=>
        perr_reg[PE_PROG_PAR])
        else $error("fatal flag cleared by write");

    a_illegal_sets_fatal: assert property (
        (i_ce && !run_start && i_err_illegal) |=>
        perr_reg[PE_ILLEGAL] && erf_reg)
        else $error("illegal opcode not flagged");

    a_cal_fault_fill: assert property (
        (i_ce && i_cal_fault) |=> (cal_reg[0] == 16'h00ff)
        && (cal_reg[6] == 16'h00ff))
        else $error("calendar fault fill missing");

    a_cal_write_ignored: assert property (
        (i_ce && wr_go && hit_cal && !cal_bad && !i_cal_update) |=>
        $stable(cal_reg[cal_idx]))
        else $error("calendar changed by bus write");

    a_check_pre_point: assert property (
        (i_ce && check_trig_reg && !check_sel_reg && i_scan_pre) |=>
        o_check_run)
        else $error("check not run before program");

    a_check_post_only: assert property (
        (i_ce && check_sel_reg && !i_scan_post) |=> !o_check_run)
        else $error("check run at wrong point");

    a_carry_update: assert property (
        (i_ce && i_carry_we) |=> (o_carry_flag == $past(i_carry_in)))
        else $error("carry not updated");

    a_waves_restart: assert property (
        (i_ce && run_start) |=> (o_timing_bits == 8'h00))
        else $error("timing bits not low at run start");

    a_bus_answer: assert property (
        (i_ce && req && wait_reg) |=> !o_avs_waitrequest ##1
        o_avs_waitrequest)
        else $error("bus answer timing wrong");

    c_run_start: cover property (i_ce && run_start);
    c_warn_cleared: cover property (
        perr_wr && perr_reg[PE_DIV] && !i_avs_writedata[PE_DIV]);
    c_check_post: cover property (i_ce && check_sel_reg && check_fire);
    c_cal_update: cover property (i_ce && i_cal_update && !cal_bad);

endmodule // ssfb_status_bank
`default_nettype wire

// >>> bench/system_status_flag_bank_tb.sv
`timescale 1ns/1ns
`default_nettype none
module system_status_flag_bank_tb;
    import ssfb_pkg::*;
    // ------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------
    // Short tick keeps the 8 s wave to a few hundred cycles
    localparam int TK = 4;
    logic clk, rst_n, rd, wr, run, cwe, cin, cupd, cflt, done, pat, wt, cf;
    logic instruction_error_flag, ckrun, iorun, ce;
    logic [3:0] addr, regm;
    logic [31:0] wd, rdat, q;
    logic [7:0] waves;
    logic [10:0] err;
    logic [7:0] cal [CAL_REGS];
    logic [1:0] scan;
    int n_fail, comparisons, pe, sub, m, k;
    ssfb_status_bank #(.TICK_CYCLES_P(TK)) DUT (.i_mclk(clk),
        .i_reset_n(rst_n), .i_ce(ce), .i_avs_address(addr),
        .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd),
        .i_avs_byteenable(4'hf), .o_avs_readdata(rdat),
        .o_avs_waitrequest(wt), .i_run_mode(run), .i_carry_we(cwe),
        .i_carry_in(cin), .i_err_illegal(err[0]), .i_err_boundary(err[1]),
        .i_err_dest(err[2]), .i_err_prog_parity(err[3]),
        .i_err_data_parity(err[4]), .i_err_divide(err[5]),
        .i_err_bcd(err[6]), .i_err_table(err[7]), .i_err_encode(err[8]),
        .i_err_label(err[9]), .i_err_nesting(err[10]),
        .i_cal_update(cupd), .i_cal_fault(cflt), .i_cal_year(cal[0]),
        .i_cal_month(cal[1]), .i_cal_day(cal[2]), .i_cal_hour(cal[3]),
        .i_cal_minute(cal[4]), .i_cal_second(cal[5]),
        .i_cal_weekday(cal[6]), .i_scan_pre(scan[0]),
        .i_scan_post(scan[1]), .i_check_done(done),
        .i_pattern_mismatch(pat), .i_reg_mismatch(regm),
        .o_timing_bits(waves), .o_carry_flag(cf),
        .o_instruction_error_flag(instruction_error_flag), .o_check_run(ckrun),
        .o_io_error_map_run(iorun));
    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic conclude();
        $display("checks %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Request stays up until waitrequest is seen low at a rising edge
    task automatic bus(logic w, logic [3:0] a, logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        addr <= a;
        wd <= d;
        wr <= w;
        rd <= !w;
        @(posedge clk);
        while (wt !== 1'b0 && n < 100) begin
            @(posedge clk);
            n++;
        end
        if (n >= 100) begin
            n_fail++;
            conclude();
        end
        q = rdat;
        wr <= 1'b0;
        rd <= 1'b0;
    endtask
    task automatic rdc(logic [3:0] a, logic [31:0] e, string nm);
        bus(1'b0, a, 32'h0);
        chk(nm, e, q);
    endtask
    task automatic run_entry();
        @(posedge clk) run <= 1'b0;
        @(posedge clk) run <= 1'b1;
        @(posedge clk);
    endtask
    // Pulse one scan point and expect the run strobe one cycle later
    task automatic scan_pt(int i, logic e);
        @(posedge clk) scan[i] <= 1'b1;
        @(posedge clk) scan[i] <= 1'b0;
        @(posedge clk) chk("check_run", {31'h0, e}, {31'h0, ckrun});
        @(posedge clk) chk("check_run_end", 32'h0, {31'h0, ckrun});
    endtask
    // ------------------------------------------------------------------
    // Stimulus
    // ------------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        #200000 n_fail++;
        conclude();
    end
    initial begin
        {rst_n, rd, wr, run, cwe, cin, cupd, cflt, done, pat} = '0;
        ce = 1'b1;
        {addr, regm, wd, err, scan} = '0;
        for (int i = 0; i < CAL_REGS; i++) cal[i] = 8'h00;
        n_fail = 0;
        comparisons = 0;
        void'($urandom(32'h800c8288));
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        rdc(4'hb, 32'h0, "unmapped");
        run <= 1'b1;
        for (k = 1; k <= 1300; k++) begin
            @(posedge clk);
            for (int g = 0; g < TIMING_BITS; g++) begin
                m = TK * HALF_PERIOD_MS[g] / TICK_PERIOD_MS;
                if (k % m == m / 2)
                    chk("wave", k / m % 2, {31'h0, waves[g]});
            end
        end
        bus(1'b1, REG_TIMING, 32'hffff_ffff);
        bus(1'b0, REG_TIMING, 32'h0);
        chk("timing_word", 32'h380, q[31:8]);
        @(posedge clk) {cwe, cin} <= 2'b10;
        @(posedge clk) cwe <= 1'b0;
        @(posedge clk) chk("carry", 32'h0, {31'h0, cf});
        bus(1'b1, 4'hb, 32'hffff_ffff);
        rdc(4'hb, 32'h0, "unmapped_wr");
        for (int r = 0; r < 6; r++) begin
            run_entry();
            rdc(REG_PROG_ERR, 32'h0, "perr_run");
            chk("erf_run", 32'h0, {31'h0, instruction_error_flag});
            chk("waves_run", 32'h0, {24'h0, waves});
            sub = (r == 0) ? 11'h7ff : $urandom % 2048;
            pe = 0;
            for (int i = 0; i < 11; i++)
                if (sub[i]) pe = pe | (1 << ((i == 0) ? 0 : i + 3));
            @(posedge clk) err <= sub[10:0];
            @(posedge clk) err <= '0;
            rdc(REG_PROG_ERR, pe, "perr");
            chk("perr_hi", pe >> 8, q >> 8);
            chk("erf", {31'h0, sub != 0}, {31'h0, instruction_error_flag});
            m = $urandom % 65536;
            bus(1'b1, REG_PROG_ERR, m);
            pe = (pe & PE_FATAL_MASK) | (m & PE_WARN_MASK);
            rdc(REG_PROG_ERR, pe, "perr_wr");
        end
        // Clear warnings, then pulse every error with the enable low
        bus(1'b1, REG_PROG_ERR, 32'h0);
        pe = pe & PE_FATAL_MASK;
        @(posedge clk) {ce, err} <= {1'b0, 11'h7ff};
        @(posedge clk) {ce, err} <= {1'b1, 11'h0};
        rdc(REG_PROG_ERR, pe, "perr_frozen");
        m = $urandom % 60;
        sub = {4'(m / 10), 4'(m % 10)};
        for (int i = 0; i < CAL_REGS; i++)
            cal[i] <= (i == 5) ? sub[7:0] : CAL_HI[i];
        @(posedge clk) cupd <= 1'b1;
        @(posedge clk) cupd <= 1'b0;
        for (int i = 0; i < CAL_REGS - 2; i++)
            rdc(REG_CAL_FIRST + i, {24'h0, CAL_HI[i]}, "cal");
        rdc(REG_CAL_LAST - 1, sub, "sec");
        rdc(REG_CAL_LAST, 32'h6, "weekday");
        bus(1'b1, REG_CAL_FIRST, 32'h0);
        rdc(REG_CAL_FIRST, 32'h99, "cal_wr");
        @(posedge clk) {cflt, cupd} <= 2'b11;
        @(posedge clk) {cflt, cupd} <= 2'b00;
        for (int i = 0; i < CAL_REGS; i++)
            rdc(REG_CAL_FIRST + i, 32'hff, "cal_fault");
        bus(1'b1, REG_CHECK, 32'h1);
        scan_pt(1, 1'b0);
        scan_pt(0, 1'b1);
        bus(1'b1, REG_CHECK, 32'h8001);
        scan_pt(0, 1'b0);
        scan_pt(1, 1'b1);
        for (int r = 0; r < 3; r++) begin
            sub = (r == 2) ? 0 : $urandom % 32;
            @(posedge clk) {done, regm, pat} <= {1'b1, sub[4:0]};
            @(posedge clk) done <= 1'b0;
            pe = 32'h8001 | (sub << 2) | (sub != 0 ? 2 : 0);
            rdc(REG_CHECK, pe, "check");
        end
        // The trigger lands at the answer edge, so look one edge later
        bus(1'b1, REG_IOMAP, 32'h1);
        @(posedge clk) chk("iomap_on", 32'h1, {31'h0, iorun});
        bus(1'b1, REG_IOMAP, 32'h0);
        @(posedge clk) chk("iomap_off", 32'h0, {31'h0, iorun});
        conclude();
    end
endmodule // system_status_flag_bank_tb
`default_nettype wire
